// ---- pkg/gpc_params.svh ----
// constants of the graphics port command register and its link
`ifndef GPC_PARAMS_SVH
`define GPC_PARAMS_SVH

`define GPC_CMD_OFFSET 8'ha8
`define GPC_CMD_RESET 32'h0000_0000
`define GPC_WORD_ADDR_LSB 2
`define GPC_RATE_LSB 0
`define GPC_RATE_1X_BIT 0
`define GPC_RATE_2X_BIT 1
`define GPC_RATE_4X_BIT 2
`define GPC_FAST_WRITE_BIT 4
`define GPC_ABOVE_4G_BIT 5
`define GPC_PORT_EN_BIT 8
`define GPC_SIDEBAND_EN_BIT 9
`define GPC_RATE_CAP_ALL 3'h7
`define GPC_SERVICE_CYCLES 4

`endif

// ---- pkg/gpc_pkg.sv ----
// types shared by both ends of the graphics port
package gpc_pkg;

    typedef logic [2:0] gpc_rate_type;
    typedef logic [7:0] gpc_byte_type;
    typedef logic [15:0] gpc_sba_cmd_type;

    typedef enum logic [0:0] {
        GPC_SBA_IDLE = 1'b0,
        GPC_SBA_RECV = 1'b1
    } gpc_sba_state_type;

    typedef enum logic [1:0] {
        GPC_M_IDLE = 2'b00,
        GPC_M_PIPE = 2'b01,
        GPC_M_SBA = 2'b10,
        GPC_M_SYNC = 2'b11
    } gpc_master_state_type;

endpackage : gpc_pkg

// ---- pkg/gpc_link_if.sv ----
// link between the graphics master and the bridge target
`timescale 1ns/1ps
interface gpc_link_if;
    logic pipe_valid;
    gpc_pkg::gpc_byte_type pipe_cmd;
    logic pipe_accept;
    logic pipe_done;
    logic sba_valid;
    gpc_pkg::gpc_byte_type sba_byte;
    logic sync_req;
    logic sync_ack;
    gpc_pkg::gpc_rate_type rate;

    modport device (
        input pipe_valid, pipe_cmd, sba_valid, sba_byte, sync_req,
        output pipe_accept, pipe_done, sync_ack, rate
    );

    modport master (
        output pipe_valid, pipe_cmd, sba_valid, sba_byte, sync_req,
        input pipe_accept, pipe_done, sync_ack, rate
    );
endinterface : gpc_link_if

// ---- design/gpc_target_end.sv ----
// bridge target end: command register and request gating
`timescale 1ns/1ps
`include "gpc_params.svh"
module gpc_target_end #(
    parameter int SERVICE_CYCLES = `GPC_SERVICE_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    gpc_link_if.device link,
    input wire logic i_cfg_wr,
    input wire logic i_cfg_rd,
    input wire logic [7:0] i_cfg_addr,
    input wire logic [3:0] i_cfg_be,
    input wire logic [31:0] i_cfg_wdata,
    input wire logic i_quad_rate_override,
    output logic [31:0] o_cfg_rdata,
    output logic o_cfg_ack,
    output logic o_port_enable,
    output logic o_sideband_enable,
    output gpc_pkg::gpc_rate_type o_rate,
    output gpc_pkg::gpc_rate_type o_status_rate_cap,
    output gpc_pkg::gpc_byte_type o_pipe_cmd,
    output logic o_pipe_cmd_valid,
    output gpc_pkg::gpc_sba_cmd_type o_sba_cmd,
    output logic o_sba_cmd_valid
);

    // counter must hold the service time and be at least one cycle
    if (SERVICE_CYCLES < 1 || SERVICE_CYCLES > 255) begin : g_bad_service
        $error("gpc_target_end: SERVICE_CYCLES out of range");
    end

    // word decode of the command register
    function automatic logic cmd_hit(input logic [7:0] addr);
        logic [7:0] base;
        base = `GPC_CMD_OFFSET;
        cmd_hit = (addr[7:`GPC_WORD_ADDR_LSB] == base[7:`GPC_WORD_ADDR_LSB]);
    endfunction : cmd_hit

    // readback image; reserved and above-4GB read zero, fast-write bit reads back as stored
    function automatic logic [31:0] cmd_word(input gpc_pkg::gpc_rate_type rate, input logic fw,
                                             input logic pen, input logic sben);
        logic [31:0] w;
        w = `GPC_CMD_RESET;
        w[`GPC_RATE_4X_BIT:`GPC_RATE_LSB] = rate;
        w[`GPC_FAST_WRITE_BIT] = fw;
        w[`GPC_ABOVE_4G_BIT] = 1'b0;
        w[`GPC_PORT_EN_BIT] = pen;
        w[`GPC_SIDEBAND_EN_BIT] = sben;
        cmd_word = w;
    endfunction : cmd_word

    gpc_pkg::gpc_rate_type rate_r, rate_nxt;
    logic fw_r, fw_nxt;
    logic pen_r, pen_nxt;
    logic sben_r, sben_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic ack_r, ack_nxt;
    gpc_pkg::gpc_rate_type cap_r, cap_nxt;
    logic [7:0] svc_r, svc_nxt;
    logic accept_r, accept_nxt;
    logic done_r, done_nxt;
    gpc_pkg::gpc_byte_type pcmd_r, pcmd_nxt;
    logic pvalid_r, pvalid_nxt;
    gpc_pkg::gpc_sba_state_type sba_r, sba_nxt;
    gpc_pkg::gpc_byte_type hi_r, hi_nxt;
    gpc_pkg::gpc_sba_cmd_type scmd_r, scmd_nxt;
    logic svalid_r, svalid_nxt;
    logic sync_r, sync_nxt;

    // next state of register file and link handling
    always_comb begin
        rate_nxt = rate_r;
        fw_nxt = fw_r;
        pen_nxt = pen_r;
        sben_nxt = sben_r;
        rdata_nxt = 32'h0000_0000;
        ack_nxt = i_cfg_wr | i_cfg_rd;
        svc_nxt = svc_r;
        accept_nxt = 1'b0;
        done_nxt = 1'b0;
        pcmd_nxt = pcmd_r;
        pvalid_nxt = 1'b0;
        sba_nxt = sba_r;
        hi_nxt = hi_r;
        scmd_nxt = scmd_r;
        svalid_nxt = 1'b0;
        sync_nxt = 1'b0;
        // capability image: 4X hidden while override is set
        cap_nxt = `GPC_RATE_CAP_ALL;
        cap_nxt[`GPC_RATE_4X_BIT] = ~i_quad_rate_override;
        // other offsets answer zero; they live in neighbouring blocks
        if (i_cfg_rd && cmd_hit(i_cfg_addr)) begin
            rdata_nxt = cmd_word(rate_r, fw_r, pen_r, sben_r);
        end
        if (i_cfg_wr && cmd_hit(i_cfg_addr)) begin
            if (i_cfg_be[0]) begin
                rate_nxt[`GPC_RATE_1X_BIT] = i_cfg_wdata[`GPC_RATE_1X_BIT];
                rate_nxt[`GPC_RATE_2X_BIT] = i_cfg_wdata[`GPC_RATE_2X_BIT];
                if (!i_quad_rate_override) begin
                    rate_nxt[`GPC_RATE_4X_BIT] = i_cfg_wdata[`GPC_RATE_4X_BIT];
                end
                // stored as written; only zero is a defined setting
                fw_nxt = i_cfg_wdata[`GPC_FAST_WRITE_BIT];
            end
            if (i_cfg_be[1]) begin
                pen_nxt = i_cfg_wdata[`GPC_PORT_EN_BIT];
                sben_nxt = i_cfg_wdata[`GPC_SIDEBAND_EN_BIT];
            end
        end
        // pipelined path: servicing runs to the end even once disabled
        if (svc_r != 8'h00) begin
            svc_nxt = svc_r - 8'h01;
            done_nxt = (svc_r == 8'h01);
        end else if (link.pipe_valid && pen_r) begin
            accept_nxt = 1'b1;
            pcmd_nxt = link.pipe_cmd;
            pvalid_nxt = 1'b1;
            svc_nxt = SERVICE_CYCLES[7:0];
        end
        // sync cycle answered only while the port is enabled
        if (link.sync_req && pen_r && !sync_r) begin
            sync_nxt = 1'b1;
        end
        // sideband capture: a started command is finished regardless of enable
        unique case (sba_r)
            gpc_pkg::GPC_SBA_IDLE: begin
                if (link.sba_valid && pen_r && sben_r) begin
                    hi_nxt = link.sba_byte;
                    sba_nxt = gpc_pkg::GPC_SBA_RECV;
                end
            end
            gpc_pkg::GPC_SBA_RECV: begin
                if (link.sba_valid) begin
                    scmd_nxt = {hi_r, link.sba_byte};
                    svalid_nxt = 1'b1;
                    sba_nxt = gpc_pkg::GPC_SBA_IDLE;
                end
            end
        endcase
    end

    // registers; all cleared by reset
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            rate_r <= 3'h0;
            fw_r <= 1'b0;
            pen_r <= 1'b0;
            sben_r <= 1'b0;
            rdata_r <= `GPC_CMD_RESET;
            ack_r <= 1'b0;
            cap_r <= 3'h0;
            svc_r <= 8'h00;
            accept_r <= 1'b0;
            done_r <= 1'b0;
            pcmd_r <= 8'h00;
            pvalid_r <= 1'b0;
            sba_r <= gpc_pkg::GPC_SBA_IDLE;
            hi_r <= 8'h00;
            scmd_r <= 16'h0000;
            svalid_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            rate_r <= rate_nxt;
            fw_r <= fw_nxt;
            pen_r <= pen_nxt;
            sben_r <= sben_nxt;
            rdata_r <= rdata_nxt;
            ack_r <= ack_nxt;
            cap_r <= cap_nxt;
            svc_r <= svc_nxt;
            accept_r <= accept_nxt;
            done_r <= done_nxt;
            pcmd_r <= pcmd_nxt;
            pvalid_r <= pvalid_nxt;
            sba_r <= sba_nxt;
            hi_r <= hi_nxt;
            scmd_r <= scmd_nxt;
            svalid_r <= svalid_nxt;
            sync_r <= sync_nxt;
        end
    end

    // one rate register drives both the link rate and o_rate; no transfer logic uses it
    assign link.rate = rate_r;
    assign link.pipe_accept = accept_r;
    assign link.pipe_done = done_r;
    assign link.sync_ack = sync_r;
    assign o_rate = rate_r;
    assign o_cfg_rdata = rdata_r;
    assign o_cfg_ack = ack_r;
    assign o_port_enable = pen_r;
    assign o_sideband_enable = sben_r;
    assign o_status_rate_cap = cap_r;
    assign o_pipe_cmd = pcmd_r;
    assign o_pipe_cmd_valid = pvalid_r;
    assign o_sba_cmd = scmd_r;
    assign o_sba_cmd_valid = svalid_r;

endmodule : gpc_target_end

// ---- design/gpc_master_end.sv ----
// graphics master end: issues requests and keeps its own rate
`timescale 1ns/1ps
`include "gpc_params.svh"
module gpc_master_end (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    gpc_link_if.master link,
    input wire logic i_rate_load,
    input wire logic [2:0] i_rate_sel,
    input wire logic i_pipe_req,
    input wire logic [7:0] i_pipe_cmd,
    input wire logic i_sba_req,
    input wire logic [15:0] i_sba_cmd,
    input wire logic i_sync_req,
    output logic o_busy,
    output logic o_pipe_accepted,
    output logic o_pipe_done,
    output logic o_sba_sent,
    output logic o_sync_done,
    output logic o_rate_match,
    output gpc_pkg::gpc_rate_type o_rate
);

    // exactly one rate bit may be selected
    function automatic logic one_hot3(input logic [2:0] v);
        one_hot3 = (v == 3'h1) || (v == 3'h2) || (v == 3'h4);
    endfunction : one_hot3

    gpc_pkg::gpc_master_state_type st_r, st_nxt;
    logic phase_r, phase_nxt;
    gpc_pkg::gpc_rate_type rate_r, rate_nxt;
    logic pv_r, pv_nxt;
    gpc_pkg::gpc_byte_type pc_r, pc_nxt;
    logic sv_r, sv_nxt;
    gpc_pkg::gpc_byte_type sb_r, sb_nxt;
    gpc_pkg::gpc_byte_type lo_r, lo_nxt;
    logic sy_r, sy_nxt;
    logic acc_r, acc_nxt;
    logic dn_r, dn_nxt;
    logic sent_r, sent_nxt;
    logic syd_r, syd_nxt;
    logic match_r, match_nxt;

    // request sequencing; pipe wins over sideband, sideband over sync
    always_comb begin
        st_nxt = st_r;
        phase_nxt = phase_r;
        rate_nxt = rate_r;
        pv_nxt = pv_r;
        pc_nxt = pc_r;
        sv_nxt = 1'b0;
        sb_nxt = sb_r;
        lo_nxt = lo_r;
        sy_nxt = sy_r;
        acc_nxt = 1'b0;
        dn_nxt = link.pipe_done;
        sent_nxt = 1'b0;
        syd_nxt = 1'b0;
        // same bit as the target; bad selections are dropped
        if (i_rate_load && one_hot3(i_rate_sel)) begin
            rate_nxt = i_rate_sel;
        end
        match_nxt = (rate_r == link.rate);
        unique case (st_r)
            gpc_pkg::GPC_M_IDLE: begin
                if (i_pipe_req) begin
                    pv_nxt = 1'b1;
                    pc_nxt = i_pipe_cmd;
                    st_nxt = gpc_pkg::GPC_M_PIPE;
                end else if (i_sba_req) begin
                    sv_nxt = 1'b1;
                    sb_nxt = i_sba_cmd[15:8];
                    lo_nxt = i_sba_cmd[7:0];
                    phase_nxt = 1'b0;
                    st_nxt = gpc_pkg::GPC_M_SBA;
                end else if (i_sync_req) begin
                    sy_nxt = 1'b1;
                    st_nxt = gpc_pkg::GPC_M_SYNC;
                end
            end
            gpc_pkg::GPC_M_PIPE: begin
                // held until taken; a disabled target never takes it
                if (link.pipe_accept) begin
                    pv_nxt = 1'b0;
                    acc_nxt = 1'b1;
                    st_nxt = gpc_pkg::GPC_M_IDLE;
                end
            end
            gpc_pkg::GPC_M_SBA: begin
                if (!phase_r) begin
                    sv_nxt = 1'b1;
                    sb_nxt = lo_r;
                    phase_nxt = 1'b1;
                end else begin
                    sent_nxt = 1'b1;
                    st_nxt = gpc_pkg::GPC_M_IDLE;
                end
            end
            gpc_pkg::GPC_M_SYNC: begin
                if (link.sync_ack) begin
                    sy_nxt = 1'b0;
                    syd_nxt = 1'b1;
                    st_nxt = gpc_pkg::GPC_M_IDLE;
                end
            end
        endcase
    end

    // state registers
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            st_r <= gpc_pkg::GPC_M_IDLE;
            phase_r <= 1'b0;
            rate_r <= 3'h1;
            pv_r <= 1'b0;
            pc_r <= 8'h00;
            sv_r <= 1'b0;
            sb_r <= 8'h00;
            lo_r <= 8'h00;
            sy_r <= 1'b0;
            acc_r <= 1'b0;
            dn_r <= 1'b0;
            sent_r <= 1'b0;
            syd_r <= 1'b0;
            match_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            phase_r <= phase_nxt;
            rate_r <= rate_nxt;
            pv_r <= pv_nxt;
            pc_r <= pc_nxt;
            sv_r <= sv_nxt;
            sb_r <= sb_nxt;
            lo_r <= lo_nxt;
            sy_r <= sy_nxt;
            acc_r <= acc_nxt;
            dn_r <= dn_nxt;
            sent_r <= sent_nxt;
            syd_r <= syd_nxt;
            match_r <= match_nxt;
        end
    end

    // busy is a registered view of the state
    logic busy_r;
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= (st_nxt != gpc_pkg::GPC_M_IDLE);
        end
    end

    assign link.pipe_valid = pv_r;
    assign link.pipe_cmd = pc_r;
    assign link.sba_valid = sv_r;
    assign link.sba_byte = sb_r;
    assign link.sync_req = sy_r;
    assign o_busy = busy_r;
    assign o_pipe_accepted = acc_r;
    assign o_pipe_done = dn_r;
    assign o_sba_sent = sent_r;
    assign o_sync_done = syd_r;
    assign o_rate_match = match_r;
    assign o_rate = rate_r;

endmodule : gpc_master_end

// ---- sim/gpc_link_checker.sv ----
// link checker: timing relations between master and target
`timescale 1ns/1ps
module gpc_link_checker #(
    parameter int SERVICE_CYCLES = 4
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic pipe_valid,
    input wire gpc_pkg::gpc_byte_type pipe_cmd,
    input wire logic pipe_accept,
    input wire logic pipe_done,
    input wire logic sba_valid,
    input wire logic sync_req,
    input wire logic sync_ack
);
    logic [7:0] svc_r;
    logic [7:0] svc_nxt;

    // cycles left in service; done must land exactly on the last one
    always_comb begin
        svc_nxt = pipe_accept ? 8'(SERVICE_CYCLES) : (svc_r != 8'h00) ? svc_r - 8'h01 : svc_r;
    end

    always_ff @(posedge i_sys_clk) begin
        svc_r <= i_sys_rst ? 8'h00 : svc_nxt;
    end

    default clocking @(posedge i_sys_clk);
    endclocking
    default disable iff (i_sys_rst);

    a_done_on_count: assert property (pipe_done == (svc_r == 8'h01))
        else $error("pipe done off its service count");
    a_accept_needs_valid: assert property (pipe_accept |-> $past(pipe_valid))
        else $error("pipe accept without a request");
    a_accept_when_idle: assert property (pipe_accept |-> svc_r == 8'h00)
        else $error("pipe accept during service");
    a_sync_ack_req: assert property (sync_ack |-> $past(sync_req))
        else $error("sync ack without request");
    a_sync_ack_once: assert property (sync_ack |=> !sync_ack && !sync_req)
        else $error("sync ack or request lingers");
    a_sync_req_held: assert property (sync_req && !sync_ack |=> sync_req)
        else $error("sync request dropped early");
    a_pipe_req_held: assert property (pipe_valid && !pipe_accept |=> pipe_valid && $stable(pipe_cmd))
        else $error("pipe request not held");
    a_sba_two_bytes: assert property ($rose(sba_valid) |=> sba_valid ##1 !sba_valid)
        else $error("sideband command not two bytes");
endmodule : gpc_link_checker

// ---- sim/tb_top.sv ----
// self-checking bench for both ends of the graphics port link
`timescale 1ns/1ps
module tb_top;
    localparam int SVC = 3; // short service keeps the run brief
    logic i_sys_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [3:0] be = 4'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic ovr = 1'b0;
    logic [3:0] req = 4'h0;
    logic [15:0] rq_d = 16'h0000;
    logic [31:0] rdata;
    logic ack, pen, sben, pv, sv, md, sd, rm, seen;
    logic pa, ss, busy;
    gpc_pkg::gpc_rate_type trate, mrate;
    gpc_pkg::gpc_rate_type cap;
    gpc_pkg::gpc_byte_type pcmd;
    gpc_pkg::gpc_sba_cmd_type scmd;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;

    always #25 i_sys_clk = ~i_sys_clk;

    gpc_link_if link();

    // both ends face each other across the link
    gpc_target_end #(.SERVICE_CYCLES(SVC)) i_gpc_target_end (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
        .link(link.device), .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_addr(addr), .i_cfg_be(be),
        .i_cfg_wdata(wdata), .i_quad_rate_override(ovr), .o_cfg_rdata(rdata), .o_cfg_ack(ack),
        .o_port_enable(pen), .o_sideband_enable(sben), .o_rate(trate), .o_status_rate_cap(cap),
        .o_pipe_cmd(pcmd), .o_pipe_cmd_valid(pv), .o_sba_cmd(scmd), .o_sba_cmd_valid(sv));
    gpc_master_end i_gpc_master_end (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .link(link.master),
        .i_rate_load(req[3]), .i_rate_sel(rq_d[2:0]), .i_pipe_req(req[0]), .i_pipe_cmd(rq_d[7:0]),
        .i_sba_req(req[1]), .i_sba_cmd(rq_d), .i_sync_req(req[2]), .o_busy(busy), .o_pipe_accepted(pa),
        .o_pipe_done(md), .o_sba_sent(ss), .o_sync_done(sd), .o_rate_match(rm), .o_rate(mrate));
    gpc_link_checker #(.SERVICE_CYCLES(SVC)) i_gpc_link_checker (.i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst), .pipe_valid(link.pipe_valid), .pipe_cmd(link.pipe_cmd),
        .pipe_accept(link.pipe_accept), .pipe_done(link.pipe_done), .sba_valid(link.sba_valid),
        .sync_req(link.sync_req), .sync_ack(link.sync_ack));

    task automatic test_done;
        $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    // config strobe for one cycle, answer looked at in the ack cycle
    task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        @(posedge i_sys_clk);
        #1;
        wr = w;
        rd = !w;
        addr = a;
        be = b;
        wdata = d;
        @(posedge i_sys_clk);
        #1;
        chk("cfg ack", 32'h0000_0001, 32'(ack));
        if (!w) begin
            chk("cfg read", d, rdata);
        end
        wr = 1'b0;
        rd = 1'b0;
    endtask : cfg

    // master request pulse: bit 0 pipe, 1 sideband, 2 sync, 3 rate load
    task automatic mreq(input logic [3:0] k, input logic [15:0] d);
        @(posedge i_sys_clk);
        #1;
        rq_d = d;
        req = k;
        @(posedge i_sys_clk);
        #1;
        req = 4'h0;
    endtask : mreq

    // bounded watch for a one-cycle completion pulse
    task automatic wait_ev(input int k, input int lim, input logic exp);
        logic ev;
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(posedge i_sys_clk);
            #1;
            ev = (k == 0) ? pv : (k == 1) ? md : (k == 2) ? sd : (k == 3) ? sv : pa;
            seen = (ev === 1'b1);
        end
        chk("event seen", 32'(exp), 32'(seen));
    endtask : wait_ev

    // cycle ceiling: the whole sequence needs well under a thousand
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            test_done();
        end
    end

    initial begin
        repeat (16) @(posedge i_sys_clk);
        #1;
        i_sys_rst = 1'b0;
        cfg(0, 8'ha8, 4'hf, 32'h0000_0000);
        chk("link rate", 32'h0000_0000, 32'(link.rate));
        cfg(1, 8'ha8, 4'hf, 32'hffff_ffec);
        cfg(0, 8'ha8, 4'hf, 32'h0000_0304);
        chk("enables", 32'h0000_0003, 32'({sben, pen}));
        cfg(1, 8'ha8, 4'hc, 32'h0000_0000);
        cfg(0, 8'ha8, 4'hf, 32'h0000_0304);
        cfg(1, 8'hac, 4'hf, 32'hffff_ffff);
        cfg(0, 8'hac, 4'hf, 32'h0000_0000);
        cfg(0, 8'ha8, 4'hf, 32'h0000_0304);
        // every rate, target and master set alike
        // master side settled and read back first, then the target follows
        for (int i = 0; i < 3; i++) begin
            mreq(4'h8, 16'h0001 << i);
            chk("master rate", 32'h0000_0001 << i, 32'(mrate));
            cfg(1, 8'ha8, 4'h3, 32'h0000_0300 | (32'h0000_0001 << i));
            repeat (3) @(posedge i_sys_clk);
            #1;
            chk("link rate", 32'h0000_0001 << i, 32'(link.rate));
            chk("target rate", 32'h0000_0001 << i, 32'(trate));
            chk("rate match", 32'h0000_0001, 32'(rm));
        end
        // a two-bit selection is never taken by the master
        mreq(4'h8, 16'h0006);
        chk("master rate", 32'h0000_0004, 32'(mrate));
        ovr = 1'b1;
        cfg(1, 8'ha8, 4'h3, 32'h0000_0301);
        cfg(0, 8'ha8, 4'hf, 32'h0000_0305);
        chk("rate cap", 32'h0000_0003, 32'(cap));
        ovr = 1'b0;
        cfg(1, 8'ha8, 4'h3, 32'h0000_0301);
        cfg(0, 8'ha8, 4'hf, 32'h0000_0301);
        chk("rate cap", 32'h0000_0007, 32'(cap));
        mreq(4'h1, 16'h005a);
        wait_ev(0, 10, 1'b1);
        chk("pipe cmd", 32'h0000_005a, 32'(pcmd));
        wait_ev(4, 4, 1'b1);
        wait_ev(1, 10, 1'b1);
        // disable while in service: completion still due
        mreq(4'h1, 16'h00c3);
        wait_ev(0, 10, 1'b1);
        cfg(1, 8'ha8, 4'h3, 32'h0000_0000);
        wait_ev(1, 10, 1'b1);
        mreq(4'h4, 16'h0000);
        wait_ev(2, 12, 1'b0);
        chk("master busy", 32'h0000_0001, 32'(busy));
        cfg(1, 8'ha8, 4'h3, 32'h0000_0101);
        wait_ev(2, 6, 1'b1);
        chk("master busy", 32'h0000_0000, 32'(busy));
        cfg(1, 8'ha8, 4'h3, 32'h0000_0000);
        mreq(4'h1, 16'h0011);
        wait_ev(0, 12, 1'b0);
        chk("master busy", 32'h0000_0001, 32'(busy));
        cfg(1, 8'ha8, 4'h3, 32'h0000_0101);
        wait_ev(0, 6, 1'b1);
        wait_ev(1, 10, 1'b1);
        // sideband needs both enables
        mreq(4'h2, 16'h1234);
        wait_ev(3, 8, 1'b0);
        cfg(1, 8'ha8, 4'h3, 32'h0000_0201);
        mreq(4'h2, 16'h2345);
        wait_ev(3, 8, 1'b0);
        cfg(1, 8'ha8, 4'h3, 32'h0000_0301);
        mreq(4'h2, 16'ha55a);
        wait_ev(3, 8, 1'b1);
        chk("sba cmd", 32'h0000_a55a, 32'(scmd));
        chk("sba sent", 32'h0000_0001, 32'(ss));
        // port disabled between the two sideband bytes at 1X
        fork
            begin
                @(posedge i_sys_clk);
                cfg(1, 8'ha8, 4'h3, 32'h0000_0000);
            end
            mreq(4'h2, 16'h0f0f);
        join
        wait_ev(3, 8, 1'b1);
        chk("sba cmd", 32'h0000_0f0f, 32'(scmd));
        test_done();
    end
endmodule : tb_top
